// file: psr_pkg.sv
// Purpose: Shared constants and types for the potentiometer serial read-back block.
// Assumes: A 125 MHz system clock samples the serial pins.
// Notes: Opcodes sit in the upper nibble of the command byte.
package psr_pkg;

  // System clock rate in MHz.
  localparam int CLK_MHZ = 125;
  // Longest store time into a stored wiper slot, in ms.
  localparam int STORE_TIME_MS = 2;
  // Store time in cycles, the exact product of store time and clock rate, as a longest time.
  localparam int STORE_CYC_DEF = STORE_TIME_MS * CLK_MHZ * 1000;

  // Serial clock pulses in one valid frame.
  localparam logic [4:0] FRAME_BITS = 5'h18;
  // Saturation value of the pulse counter, one above a valid frame.
  localparam logic [4:0] FRAME_OVER = 5'h19;
  // Width of one frame in bits.
  localparam int FRAME_W = 24;
  // Width of a stored word, buffer mode bit plus eight wiper bits.
  localparam int WORD_W = 9;
  // Number of channels and of stored slots.
  localparam int CHANNELS = 4;
  localparam int SLOTS_TOTAL = 16;

  // Frame field positions.
  localparam int OP_HI = 23;
  localparam int OP_LO = 20;
  localparam int ADDR_HI = 19;
  localparam int ADDR_LO = 16;
  // Bit that holds the buffer mode bit in a stored word.
  localparam int BUF_BIT = 8;

  // Command opcodes.
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_WAKE = 4'h1;
  localparam logic [3:0] OP_PROGRAM = 4'h2;
  localparam logic [3:0] OP_STORE_TAP = 4'h3;
  localparam logic [3:0] OP_WRITE_TAP = 4'h4;
  localparam logic [3:0] OP_SLEEP = 4'h8;
  localparam logic [3:0] OP_RESET = 4'h9;
  localparam logic [3:0] OP_READ_SLOT = 4'ha;
  localparam logic [3:0] OP_LOAD_TAP = 4'hb;
  localparam logic [3:0] OP_READ_TAP = 4'hc;

  // Slot that is recalled into the wiper after power-up or reset.
  localparam logic [1:0] RECALL_SLOT = 2'h0;
  // Last channel index.
  localparam logic [1:0] LAST_CHAN = 2'h3;

  // Sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_APPLY = 2'b10,
    SEQ_STORE = 2'b11
  } psr_seq_e;

  // What to do with a fetched stored word.
  typedef enum logic [1:0] {
    USE_READ = 2'b00,
    USE_LOAD = 2'b01,
    USE_INIT = 2'b10
  } psr_use_e;

  // Three-stage pin synchroniser with its filtered level.
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } psr_sync_s;

  // Stored-slot memory request.
  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [WORD_W-1:0] wdata;
  } psr_mem_req_s;

endpackage

// file: psr_slot_mem.sv
// Purpose: Small memory holding the stored wiper slots of all channels.
// Assumes: One access per cycle, write or read, with a registered read.
// Notes: Contents clear under reset so simulation starts from known words.
`timescale 1ns/1ps

module psr_slot_mem
  import psr_pkg::*;
#(
  parameter int DEPTH = SLOTS_TOTAL,
  parameter int WIDTH = WORD_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire psr_mem_req_s req,
  output logic [WIDTH-1:0] rdata
);

  // Storage array, one word per slot and channel.
  logic [DEPTH-1:0][WIDTH-1:0] mem_reg;

  // Writes store the word; every cycle the addressed word is registered out.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_reg <= '0;
      rdata <= '0;
    end else begin
      if (req.we) begin
        mem_reg[req.addr] <= req.wdata;
      end
      rdata <= mem_reg[req.addr];
    end
  end

endmodule // psr_slot_mem

// file: psr_readback.sv
// Purpose: Serial command slave of a four-channel potentiometer with read-back.
// Assumes: Serial pins come from another clock domain and are oversampled.
// Notes: Read data leaves on the frame after the read command.
`timescale 1ns/1ps

// Behaviour
// - Host can read any wiper or slot.
// - Read data shifts out on falling clock.
// - Read data appears in the next frame.
// - Opcode 1010 selects a slot and channel.
// - Opcode 1100 selects a channel's wiper value.
// - Answer is buffer bit then eight wiper bits.
// - Store finishes within 2 ms, ready low meanwhile.
// - A frame is exactly 24 clock pulses.
// - Asleep after reset; only wake is obeyed.
module psr_readback
  import psr_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYC_DEF,
  parameter int CNT_W = $clog2(STORE_CYCLES + 1)
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output logic ready,
  output logic asleep,
  output logic [CHANNELS-1:0][7:0] wiper_tap_register,
  output logic [CHANNELS-1:0] buffer_mode_bit
);

  // Whole state of the block.
  typedef struct packed {
    psr_sync_s sclk_s;
    psr_sync_s cs_s;
    psr_sync_s sdi_s;
    logic [4:0] bit_cnt;
    logic [FRAME_W-1:0] in_shift;
    logic [FRAME_W-1:0] out_shift;
    logic sdo;
    logic sdo_oe_n;
    logic ready;
    logic asleep;
    psr_seq_e seq;
    psr_use_e use_kind;
    logic [1:0] chan;
    logic [CNT_W-1:0] busy_cnt;
    psr_mem_req_s mem;
    logic [CHANNELS-1:0][7:0] taps;
    logic [CHANNELS-1:0] bufm;
  } psr_state_s;

  psr_state_s state_reg; // Registered state.
  psr_state_s state_next; // Next state.
  logic [WORD_W-1:0] slot_rdata; // Registered read data from the slot memory.

  // Cycles still to wait once a store begins, sized for the counter.
  localparam logic [CNT_W-1:0] STORE_LOAD = CNT_W'(STORE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // Builds the answer frame: buffer bit lowest in the first data byte, wiper in the second.
  function automatic logic [FRAME_W-1:0] answer_word(input logic [WORD_W-1:0] word);
    answer_word = {{(FRAME_W - WORD_W){1'b0}}, word};
  endfunction

  // Moves a pin through three flip-flops and takes a new level once the last two agree.
  function automatic psr_sync_s pin_sync(input psr_sync_s s, input logic pin);
    psr_sync_s o;
    o.stage = {s.stage[1:0], pin};
    o.level = (s.stage[1] == s.stage[2]) ? s.stage[2] : s.level;
    pin_sync = o;
  endfunction

  // Stored slot words.
  psr_slot_mem #(
    .DEPTH(SLOTS_TOTAL),
    .WIDTH(WORD_W)
  ) u_slot_mem (
    .clock(clock),
    .resetn(resetn),
    .req(state_reg.mem),
    .rdata(slot_rdata)
  );

  // Next-state logic: pin sampling, framing, command decode and the sequencer.
  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic [3:0] op;
    logic [3:0] addr;
    logic [1:0] ch;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    op = '0;
    addr = '0;
    ch = '0;
    state_next = state_reg;
    state_next.mem.we = 1'b0;
    state_next.sclk_s = pin_sync(state_reg.sclk_s, sclk);
    state_next.cs_s = pin_sync(state_reg.cs_s, cs_n);
    state_next.sdi_s = pin_sync(state_reg.sdi_s, sdi);
    sclk_rise = state_next.sclk_s.level & ~state_reg.sclk_s.level;
    sclk_fall = ~state_next.sclk_s.level & state_reg.sclk_s.level;
    cs_fall = ~state_next.cs_s.level & state_reg.cs_s.level;
    cs_rise = state_next.cs_s.level & ~state_reg.cs_s.level;
    op = state_reg.in_shift[OP_HI:OP_LO];
    addr = state_reg.in_shift[ADDR_HI:ADDR_LO];
    ch = addr[1:0];

    // Frame start clears the pulse count.
    if (cs_fall) begin
      state_next.bit_cnt = '0;
    end else if (!state_reg.cs_s.level) begin
      // Rising edges take in command bits and count pulses up to saturation.
      if (sclk_rise) begin
        state_next.in_shift = {state_reg.in_shift[FRAME_W-2:0], state_next.sdi_s.level};
        if (state_reg.bit_cnt != FRAME_OVER) begin
          state_next.bit_cnt = state_reg.bit_cnt + 5'h1;
        end
      end
      // Falling edges move the next answer bit out after the host has sampled.
      if (sclk_fall) begin
        state_next.out_shift = {state_reg.out_shift[FRAME_W-2:0], 1'b0};
      end
    end

    // Frame end: only a 24-pulse frame taken while idle is obeyed.
    if (cs_rise) begin
      state_next.out_shift = '0;
      if (state_reg.bit_cnt == FRAME_BITS && state_reg.seq == SEQ_IDLE) begin
        if (state_reg.asleep) begin
          // While asleep every command but wake-up is dropped.
          if (op == OP_WAKE) begin
            state_next.asleep = 1'b0;
          end
        end else begin
          case (op)
            OP_SLEEP: begin
              state_next.asleep = 1'b1;
            end
            OP_RESET: begin
              // Back to the power-up state: asleep, with slot recall.
              state_next.asleep = 1'b1;
              state_next.seq = SEQ_FETCH;
              state_next.use_kind = USE_INIT;
              state_next.chan = '0;
              state_next.mem.addr = {RECALL_SLOT, 2'h0};
            end
            OP_READ_TAP: begin
              // Answer is ready at once for the next frame.
              state_next.out_shift = answer_word({state_reg.bufm[ch], state_reg.taps[ch]});
              state_next.seq = SEQ_APPLY;
              state_next.use_kind = USE_INIT;
              state_next.chan = LAST_CHAN;
              state_next.mem.addr = {RECALL_SLOT, ch};
            end
            OP_READ_SLOT: begin
              state_next.seq = SEQ_FETCH;
              state_next.use_kind = USE_READ;
              state_next.mem.addr = addr;
            end
            OP_LOAD_TAP: begin
              state_next.seq = SEQ_FETCH;
              state_next.use_kind = USE_LOAD;
              state_next.chan = ch;
              state_next.mem.addr = addr;
            end
            OP_WRITE_TAP: begin
              state_next.taps[ch] = state_reg.in_shift[7:0];
            end
            OP_PROGRAM, OP_STORE_TAP: begin
              // Store a word and hold ready low for the store time.
              state_next.mem.we = 1'b1;
              state_next.mem.addr = addr;
              state_next.mem.wdata = (op == OP_PROGRAM) ? state_reg.in_shift[WORD_W-1:0] :
                                     {state_reg.bufm[ch], state_reg.taps[ch]};
              state_next.seq = SEQ_STORE;
              state_next.busy_cnt = STORE_LOAD;
            end
            default: begin
              // No-op, wake-up and other commands change nothing here.
              state_next.seq = state_reg.seq;
            end
          endcase
        end
      end
    end

    // Sequencer for memory fetches and stores.
    case (state_reg.seq)
      SEQ_FETCH: begin
        state_next.seq = SEQ_APPLY;
      end
      SEQ_APPLY: begin
        if (state_reg.use_kind == USE_READ) begin
          state_next.out_shift = answer_word(slot_rdata);
          state_next.seq = SEQ_IDLE;
        end else if (state_reg.use_kind == USE_LOAD) begin
          state_next.taps[state_reg.chan] = slot_rdata[7:0];
          state_next.bufm[state_reg.chan] = slot_rdata[BUF_BIT];
          state_next.seq = SEQ_IDLE;
        end else if (state_reg.chan == LAST_CHAN) begin
          // A read-tap pass ends here, as does the last recall step.
          // Recall only runs while asleep, and reads only while awake, so a read of a
          // zero wiper can never be taken for the last recall step.
          if (state_reg.mem.addr[3:2] == RECALL_SLOT && state_reg.use_kind == USE_INIT
              && state_reg.asleep) begin
            state_next.taps[LAST_CHAN] = slot_rdata[7:0];
            state_next.bufm[LAST_CHAN] = slot_rdata[BUF_BIT];
          end
          state_next.seq = SEQ_IDLE;
        end else begin
          // Recall slot zero into each channel in turn.
          state_next.taps[state_reg.chan] = slot_rdata[7:0];
          state_next.bufm[state_reg.chan] = slot_rdata[BUF_BIT];
          state_next.chan = state_reg.chan + 2'h1;
          state_next.mem.addr = {RECALL_SLOT, state_reg.chan + 2'h1};
          state_next.seq = SEQ_FETCH;
        end
      end
      SEQ_STORE: begin
        // Count down the store time, then report ready again.
        if (state_reg.busy_cnt <= CNT_ONE) begin
          state_next.seq = SEQ_IDLE;
        end else begin
          state_next.busy_cnt = state_reg.busy_cnt - CNT_ONE;
        end
      end
      default: begin
        state_next.seq = state_next.seq;
      end
    endcase

    // Output flops follow the next state so every pin comes from a register.
    state_next.sdo = state_next.out_shift[FRAME_W-1];
    state_next.sdo_oe_n = state_next.cs_s.level;
    state_next.ready = (state_next.seq == SEQ_IDLE);
  end

  // State register; after reset the block recalls slot zero and stays asleep.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.sclk_s <= '{stage: 3'h0, level: 1'b0};
      state_reg.cs_s <= '{stage: 3'h7, level: 1'b1};
      state_reg.sdo_oe_n <= 1'b1;
      state_reg.asleep <= 1'b1;
      state_reg.seq <= SEQ_FETCH;
      state_reg.use_kind <= USE_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ports straight from the state register.
  assign sdo = state_reg.sdo;
  assign sdo_oe_n = state_reg.sdo_oe_n;
  assign ready = state_reg.ready;
  assign asleep = state_reg.asleep;
  assign wiper_tap_register = state_reg.taps;
  assign buffer_mode_bit = state_reg.bufm;

endmodule // psr_readback

// file: psr_properties.sv
// Purpose: Concurrent checks on the ports of the serial read-back block.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes: Pin levels reach the core some four clocks late, so the spans allow for that.
`timescale 1ns/1ps
module psr_props
  import psr_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYC_DEF
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic ready,
  input wire logic asleep,
  input wire logic [CHANNELS-1:0][7:0] wiper_tap_register,
  input wire logic [CHANNELS-1:0] buffer_mode_bit
);
  // Counts the cycles that ready has stayed low in a row.
  int busy_len_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) busy_len_reg <= 0;
    else busy_len_reg <= ready ? 0 : busy_len_reg + 1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  idle_release_a: assert property (cs_n [*6] |-> sdo_oe_n)
    else $error("data line driven while deselected");
  frame_drive_a: assert property (!cs_n [*6] |-> !sdo_oe_n)
    else $error("data line not driven in a frame");
  busy_bound_a: assert property (busy_len_reg <= STORE_CYCLES + 16)
    else $error("busy for too long");
  busy_after_frame_a: assert property ($fell(ready) |-> cs_n && $past(cs_n, 3))
    else $error("busy began inside a frame");
  state_hold_a: assert property (
    !$stable({buffer_mode_bit, wiper_tap_register}) |-> cs_n && $past(cs_n, 3))
    else $error("wiper changed inside a frame");
  wake_only_a: assert property ($fell(asleep) |-> $past(cs_n, 3) && $past(ready))
    else $error("woke up without a finished frame");
  ready_rise_a: assert property ($rose(ready) |-> cs_n)
    else $error("ready rose inside a frame");
  frame_zero_a: assert property ($fell(sdo_oe_n) |-> !sdo [*8])
    else $error("answer does not start with zero bits");
endmodule // psr_props

bind psr_readback psr_props #(.STORE_CYCLES(STORE_CYCLES)) i_props (.clock(clock),
  .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
  .ready(ready), .asleep(asleep), .wiper_tap_register(wiper_tap_register),
  .buffer_mode_bit(buffer_mode_bit));

// file: psr_host.sv
// Purpose: Host model that sends command frames and collects the answer.
// Assumes: Pins change on falling system clock edges; serial clock is 64 ns.
// Notes: A released data line reads as the inverse of its last driven value.
`timescale 1ns/1ps
module psr_host (
  input wire logic clock,
  input wire logic ready,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  logic last_reg = 1'b0;
  logic line;
  // A floating line must never look like valid data.
  assign line = sdo_oe_n ? ~last_reg : sdo;
  always @(posedge clock) begin
    if (!sdo_oe_n) last_reg <= sdo;
  end
  // Serial clock stands low and the block is deselected outside frames.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Sends n pulses of cmd, most significant bit first, sampling on each fall.
  task automatic frame(input int n, input logic [23:0] cmd, output logic [23:0] rx);
    int k;
    k = 0;
    while (!ready && k < 2000) begin
      @(negedge clock);
      k++;
    end
    repeat (64) @(negedge clock);
    cs_n = 1'b0;
    repeat (16) @(negedge clock);
    for (int i = 0; i < n; i++) begin
      sdi = cmd[23 - (i % 24)];
      // Low and high phases of the serial clock are four system clocks each.
      repeat (4) @(negedge clock);
      sclk = 1'b1;
      repeat (4) @(negedge clock);
      rx = {rx[22:0], line};
      sclk = 1'b0;
    end
    repeat (16) @(negedge clock);
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (80) @(negedge clock);
  endtask
endmodule // psr_host

// file: tb.sv
// Purpose: Self-checking bench of the serial read-back block.
// Assumes: The host model drives the serial pins; store time is cut to 20 cycles.
// Notes: A model of slots, taps and the next answer is kept; taps are compared after each frame, answers after 24-pulse ones.
`timescale 1ns/1ps
module tb;
  import psr_pkg::*;
  logic clock = 1'b0;
  logic resetn;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, ready, asleep;
  logic [CHANNELS-1:0][7:0] wiper_tap_register;
  logic [CHANNELS-1:0] buffer_mode_bit;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rng = 32'h40;
  // Model state: slots, taps with buffer bit, sleep flag and the pending answer.
  logic [8:0] slot_m [SLOTS_TOTAL];
  logic [8:0] tap_m [CHANNELS];
  logic [23:0] ans_m, rx;
  logic sleep_m;
  psr_readback #(.STORE_CYCLES(20)) i_dut (.clock(clock), .resetn(resetn), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .ready(ready), .asleep(asleep),
    .wiper_tap_register(wiper_tap_register), .buffer_mode_bit(buffer_mode_bit));
  psr_host i_host (.clock(clock), .ready(ready), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  initial begin
    forever #4 clock = ~clock;
  end
  // Cuts a hang short.
  initial begin
    #700000;
    error_cnt++;
    end_of_test();
  end
  function automatic logic [15:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0];
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Resets the block for 10 cycles; the slots clear as well.
  task automatic hw_reset();
    resetn = 1'b0;
    foreach (slot_m[i]) slot_m[i] = 9'h0;
    foreach (tap_m[i]) tap_m[i] = 9'h0;
    ans_m = 24'h0;
    sleep_m = 1'b1;
    repeat (10) @(negedge clock);
    resetn = 1'b1;
  endtask
  // Sends one frame, checks the answer collected, then updates the model.
  task automatic cmd(input logic [3:0] op, input logic [3:0] ad, input logic [15:0] d,
    input int n);
    i_host.frame(n, {op, ad, d}, rx);
    if (n == 24) check(rx, ans_m);
    ans_m = 24'h0;
    if (n != 24) ans_m = 24'h0;
    else if (sleep_m) sleep_m = (op != OP_WAKE);
    else case (op)
      OP_READ_SLOT: ans_m = {15'h0, slot_m[ad]};
      OP_READ_TAP: ans_m = {15'h0, tap_m[ad[1:0]]};
      OP_PROGRAM: slot_m[ad] = d[8:0];
      OP_STORE_TAP: slot_m[ad] = tap_m[ad[1:0]];
      OP_WRITE_TAP: tap_m[ad[1:0]][7:0] = d[7:0];
      OP_LOAD_TAP: tap_m[ad[1:0]] = slot_m[ad];
      OP_SLEEP: sleep_m = 1'b1;
      OP_RESET: begin
        foreach (tap_m[c]) tap_m[c] = slot_m[c];
        sleep_m = 1'b1;
      end
      default: ;
    endcase
    check({23'h0, ready}, 24'h1);
    check({23'h0, asleep}, {23'h0, sleep_m});
    for (int c = 0; c < CHANNELS; c++)
      check({15'h0, buffer_mode_bit[c], wiper_tap_register[c]}, {15'h0, tap_m[c]});
  endtask
  initial begin
    hw_reset();
    cmd(OP_READ_TAP, 4'h1, xs(), 24);
    cmd(OP_WAKE, 4'h0, xs(), 24);
    for (int a = 0; a < SLOTS_TOTAL; a++) cmd(OP_PROGRAM, a[3:0], xs() & 16'h01ff, 24);
    for (int a = 0; a < SLOTS_TOTAL; a++) cmd(OP_READ_SLOT, a[3:0], xs(), 24);
    for (int a = 0; a < SLOTS_TOTAL; a++) begin
      cmd(OP_LOAD_TAP, a[3:0], xs(), 24);
      cmd(OP_READ_TAP, a[3:0], xs(), 24);
    end
    for (int a = 0; a < CHANNELS; a++) cmd(OP_WRITE_TAP, a[3:0], xs(), 24);
    cmd(OP_WRITE_TAP, 4'h2, xs(), 23);
    cmd(OP_WRITE_TAP, 4'h2, xs(), 25);
    cmd(OP_STORE_TAP, 4'h9, xs(), 24);
    cmd(OP_READ_SLOT, 4'h9, xs(), 24);
    cmd(4'hd, 4'h9, xs(), 24);
    cmd(4'h7, 4'h9, xs(), 24);
    cmd(4'hf, 4'h9, xs(), 24);
    cmd(OP_WRITE_TAP, 4'h2, 16'h0000, 24);
    cmd(OP_READ_TAP, 4'h2, xs(), 24);
    cmd(OP_SLEEP, 4'h0, xs(), 24);
    cmd(OP_WRITE_TAP, 4'h1, xs(), 24);
    cmd(OP_WAKE, 4'h0, xs(), 24);
    cmd(OP_RESET, 4'h0, xs(), 24);
    cmd(OP_WAKE, 4'h0, xs(), 24);
    cmd(OP_READ_TAP, 4'h3, xs(), 24);
    hw_reset();
    cmd(OP_WAKE, 4'h0, xs(), 24);
    cmd(OP_READ_SLOT, 4'h9, xs(), 24);
    cmd(OP_NOP, 4'h0, xs(), 24);
    end_of_test();
  end
endmodule // tb
